// >>> rtl/fault_indicator.sv
// Purpose: Fault lamp indicator with history and status reporting
// Assumes: All inputs synchronous to mclk; hist_clr is a one-cycle pulse
// Notes: Long counts are top parameters so simulation can shorten them
//
// Contract
// - No fault active: status lamp held steadily on, no flashing.
// - Fault active: its two-digit code flashes repeatedly until it clears.
// - One code at a time; highest priority shown until cleared, then next.
// - History records every fault since last clear; programmer reads and clears.
// - Active faults and input/output state readable by the programmer.
// - Fixed two-digit code per fault, e.g. undervoltage 1,4, main fault 2,3.
// - Wiring fault held ten seconds latches high pedal disable until key cycled.
module fault_indicator #(
    parameter int unsigned TICK_CYCLES = fault_pkg::TICK_CYCLES_DEF,
    parameter int unsigned WIRE_HOLD_CYCLES = fault_pkg::WIRE_HOLD_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [fault_pkg::NUM_IN-1:0] fault_in,
    input wire logic key_switch_input,
    input wire logic [fault_pkg::IO_W-1:0] io_in,
    input wire logic hist_clr,
    output logic status_lamp,
    output logic high_pedal_disable,
    output logic [fault_pkg::NUM_FAULTS-1:0] active_report,
    output logic [fault_pkg::NUM_FAULTS-1:0] history,
    output logic [fault_pkg::IO_W+1:0] io_report
);
    fault_show_if sh ();

    logic [fault_pkg::DIV_W-1:0] div_ff;
    logic tick_ff;
    logic [fault_pkg::WIRE_W-1:0] wire_cnt_ff;
    logic hpd_ff;
    logic [fault_pkg::NUM_FAULTS-1:0] active;
    logic [fault_pkg::SEL_W-1:0] hi_idx;
    logic [fault_pkg::SEL_W-1:0] sel_ff;
    logic sel_valid_ff;
    logic [fault_pkg::NUM_FAULTS-1:0] history_ff;
    logic [fault_pkg::NUM_FAULTS-1:0] active_report_ff;
    logic [fault_pkg::IO_W+1:0] io_report_ff;
    logic wire_full;

    assign active = {hpd_ff, fault_in};
    assign wire_full = wire_cnt_ff == fault_pkg::WIRE_W'(WIRE_HOLD_CYCLES - 1);

    // ==========================================================
    // Tick divider
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == fault_pkg::DIV_W'(TICK_CYCLES - 1)) begin
            div_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= fault_pkg::DIV_W'(div_ff + 1'b1);
            tick_ff <= 1'b0;
        end
    end

    // ==========================================================
    // High pedal disable latch
    // Continuous wiring fault timer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wire_cnt_ff <= '0;
        end else if (!key_switch_input || !fault_in[fault_pkg::IDX_WIRING]) begin
            wire_cnt_ff <= '0;
        end else if (!wire_full) begin
            wire_cnt_ff <= fault_pkg::WIRE_W'(wire_cnt_ff + 1'b1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hpd_ff <= 1'b0;
        end else if (!key_switch_input) begin
            hpd_ff <= 1'b0;
        end else if (fault_in[fault_pkg::IDX_WIRING] && wire_full) begin
            hpd_ff <= 1'b1;
        end
    end

    // ==========================================================
    // Priority selection
    // Lowest index wins
    always_comb begin
        hi_idx = '0;
        for (int i = fault_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
            if (active[i]) begin
                hi_idx = fault_pkg::SEL_W'(i);
            end
        end
    end

    // Hold the shown fault until it clears
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sel_ff <= '0;
            sel_valid_ff <= 1'b0;
        end else if (!sel_valid_ff || !active[sel_ff]) begin
            sel_ff <= hi_idx;
            sel_valid_ff <= |active;
        end
    end

    // Code of the shown fault to the sequencer
    assign sh.tick_en = tick_ff;
    assign sh.code_valid = sel_valid_ff;
    assign sh.code = fault_pkg::FAULT_CODE[sel_ff];

    code_blinker u_blinker (
        .mclk(mclk),
        .rst_b(rst_b),
        .sh(sh)
    );

    // ==========================================================
    // Programmer view
    // Set wins over clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            history_ff <= '0;
        end else begin
            history_ff <= (hist_clr ? '0 : history_ff) | active;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            active_report_ff <= '0;
            io_report_ff <= '0;
        end else begin
            active_report_ff <= active;
            io_report_ff <= {key_switch_input, sh.lamp, io_in};
        end
    end

    assign status_lamp = sh.lamp;
    assign high_pedal_disable = hpd_ff;
    assign active_report = active_report_ff;
    assign history = history_ff;
    assign io_report = io_report_ff;

    // ==========================================================
    // Checks
    localparam int unsigned RUN_MAX = TICK_CYCLES * fault_pkg::PULSE_ON_T + 2;
    logic [fault_pkg::DIV_W+1:0] on_run_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            on_run_ff <= '0;
        end else if (!sh.lamp || !sel_valid_ff) begin
            on_run_ff <= '0;
        end else begin
            on_run_ff <= (fault_pkg::DIV_W + 2)'(on_run_ff + 1'b1);
        end
    end

    property p_lamp_steady;
        @(posedge mclk) disable iff (!rst_b)
        (active == '0) [*3] |-> status_lamp;
    endproperty
    a_lamp_steady: assert property (p_lamp_steady) else $error("lamp not steady on without faults");

    property p_lamp_flashes;
        @(posedge mclk) disable iff (!rst_b)
        sel_valid_ff |-> on_run_ff <= RUN_MAX;
    endproperty
    a_lamp_flashes: assert property (p_lamp_flashes) else $error("lamp stuck on while a fault is shown");

    property p_pick_highest;
        @(posedge mclk) disable iff (!rst_b)
        (!sel_valid_ff && active != '0) |=> sel_valid_ff && sel_ff == $past(hi_idx);
    endproperty
    a_pick_highest: assert property (p_pick_highest) else $error("not the highest priority fault");

    property p_hold_shown;
        @(posedge mclk) disable iff (!rst_b)
        (sel_valid_ff && active[sel_ff]) |=> sel_valid_ff && $stable(sel_ff);
    endproperty
    a_hold_shown: assert property (p_hold_shown) else $error("shown fault changed while still active");

    property p_history_records;
        @(posedge mclk) disable iff (!rst_b)
        ##1 ((history & $past(active)) == $past(active));
    endproperty
    a_history_records: assert property (p_history_records) else $error("fault missing from history");

    property p_report_active;
        @(posedge mclk) disable iff (!rst_b)
        ##1 (active_report == $past(active)) && (io_report[fault_pkg::IO_W-1:0] == $past(io_in));
    endproperty
    a_report_active: assert property (p_report_active) else $error("report does not follow inputs");

    property p_undervoltage_code;
        @(posedge mclk) disable iff (!rst_b)
        (sel_valid_ff && sel_ff == fault_pkg::IDX_UNDERV) |-> sh.code == 8'h14;
    endproperty
    a_undervoltage_code: assert property (p_undervoltage_code) else $error("undervoltage code wrong");

    property p_hpd_after_hold;
        @(posedge mclk) disable iff (!rst_b)
        $rose(hpd_ff) |-> $past(wire_full) && $past(fault_in[fault_pkg::IDX_WIRING]);
    endproperty
    a_hpd_after_hold: assert property (p_hpd_after_hold) else $error("pedal disable set early");

    property p_hpd_sticks;
        @(posedge mclk) disable iff (!rst_b)
        (hpd_ff && key_switch_input) |=> hpd_ff;
    endproperty
    a_hpd_sticks: assert property (p_hpd_sticks) else $error("pedal disable cleared without key cycle");
endmodule

// >>> rtl/fault_pkg.sv
// Purpose: Shared constants for the fault lamp indicator
// Assumes: 40 MHz mclk
// Notes: Lamp timing is counted in ticks of TICK_MS
package fault_pkg;
    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_MS = 250;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned WIRE_HOLD_S = 10;
    localparam int unsigned WIRE_HOLD_CYCLES_DEF = CLK_HZ * WIRE_HOLD_S;
    localparam int DIV_W = 24;
    localparam int WIRE_W = 29;
    // Lamp pattern lengths, in ticks
    localparam logic [3:0] PULSE_ON_T = 4'h1;
    localparam logic [3:0] PULSE_OFF_T = 4'h1;
    localparam logic [3:0] DIGIT_GAP_T = 4'h4;
    localparam logic [3:0] REPEAT_GAP_T = 4'h8;

    // ==========================================================
    // Fault set, lowest index has highest priority
    localparam int NUM_IN = 10;
    localparam int NUM_FAULTS = 11;
    localparam int SEL_W = 4;
    localparam int IO_W = 8;
    localparam logic [SEL_W-1:0] IDX_THERMAL = 4'h0;
    localparam logic [SEL_W-1:0] IDX_THROTTLE = 4'h1;
    localparam logic [SEL_W-1:0] IDX_UNDERV = 4'h2;
    localparam logic [SEL_W-1:0] IDX_OVERV = 4'h3;
    localparam logic [SEL_W-1:0] IDX_MAIN_OFF = 4'h4;
    localparam logic [SEL_W-1:0] IDX_EMR_SEQ = 4'h5;
    localparam logic [SEL_W-1:0] IDX_MAIN = 4'h6;
    localparam logic [SEL_W-1:0] IDX_MAIN_ON = 4'h7;
    localparam logic [SEL_W-1:0] IDX_PUMP = 4'h8;
    localparam logic [SEL_W-1:0] IDX_WIRING = 4'h9;
    localparam logic [SEL_W-1:0] IDX_HPD = 4'ha;
    // Two-digit codes, tens digit in the upper nibble
    localparam logic [NUM_FAULTS-1:0][7:0] FAULT_CODE = {
        8'h32, 8'h31, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21, 8'h15, 8'h14, 8'h12, 8'h11
    };

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PON,
        ST_POFF,
        ST_DGAP,
        ST_RGAP
    } blink_state_t;
endpackage

// >>> rtl/fault_show_if.sv
// Purpose: Carries the selected code from the selector to the lamp sequencer
// Assumes: Single mclk domain
// Notes: lamp is registered in the sequencer
interface fault_show_if;
    logic tick_en;
    logic code_valid;
    logic [7:0] code;
    logic lamp;

    modport src (
        output tick_en,
        output code_valid,
        output code,
        input lamp
    );
    modport show (
        input tick_en,
        input code_valid,
        input code,
        output lamp
    );
endinterface

// >>> rtl/code_blinker.sv
// Purpose: Flashes a two-digit code on the lamp, steady on when idle
// Assumes: tick_en is a one-cycle pulse every tick
// Notes: First pulse may be up to one tick short, the divider is free running
module code_blinker (
    input wire logic mclk,
    input wire logic rst_b,
    fault_show_if.show sh
);
    fault_pkg::blink_state_t state_ff;
    logic [3:0] tcnt_ff;
    logic [3:0] pcnt_ff;
    logic dig_ff;
    logic [7:0] cur_ff;
    logic lamp_ff;
    logic [3:0] digit;
    logic [3:0] pnext;
    logic restart;

    assign digit = dig_ff ? cur_ff[3:0] : cur_ff[7:4];
    assign pnext = 4'(pcnt_ff + 4'h1);
    assign restart = sh.code_valid && (state_ff == fault_pkg::ST_IDLE || sh.code != cur_ff);
    assign sh.lamp = lamp_ff;

    // ==========================================================
    // Sequencer
    // Steady on, pulses and gaps
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= fault_pkg::ST_IDLE;
            tcnt_ff <= 4'h0;
            pcnt_ff <= 4'h0;
            dig_ff <= 1'b0;
            cur_ff <= 8'h00;
            lamp_ff <= 1'b1;
        end else if (!sh.code_valid) begin
            state_ff <= fault_pkg::ST_IDLE;
            lamp_ff <= 1'b1;
        end else if (restart) begin
            cur_ff <= sh.code;
            tcnt_ff <= 4'h0;
            pcnt_ff <= 4'h0;
            dig_ff <= 1'b0;
            if (state_ff == fault_pkg::ST_IDLE) begin
                state_ff <= fault_pkg::ST_PON;
                lamp_ff <= 1'b1;
            end else begin
                // A code change mid-pattern opens with a long dark gap, so a lit pulse of
                // the old code never runs into the first pulse of the new one
                state_ff <= fault_pkg::ST_RGAP;
                lamp_ff <= 1'b0;
            end
        end else if (sh.tick_en) begin
            tcnt_ff <= 4'(tcnt_ff + 4'h1);
            case (state_ff)
                fault_pkg::ST_PON: begin
                    if (tcnt_ff == 4'(fault_pkg::PULSE_ON_T - 4'h1)) begin
                        tcnt_ff <= 4'h0;
                        lamp_ff <= 1'b0;
                        pcnt_ff <= pnext;
                        if (pnext != digit) begin
                            state_ff <= fault_pkg::ST_POFF;
                        end else if (dig_ff) begin
                            state_ff <= fault_pkg::ST_RGAP;
                        end else begin
                            state_ff <= fault_pkg::ST_DGAP;
                        end
                    end
                end
                fault_pkg::ST_POFF: begin
                    if (tcnt_ff == 4'(fault_pkg::PULSE_OFF_T - 4'h1)) begin
                        tcnt_ff <= 4'h0;
                        lamp_ff <= 1'b1;
                        state_ff <= fault_pkg::ST_PON;
                    end
                end
                fault_pkg::ST_DGAP: begin
                    if (tcnt_ff == 4'(fault_pkg::DIGIT_GAP_T - 4'h1)) begin
                        tcnt_ff <= 4'h0;
                        pcnt_ff <= 4'h0;
                        dig_ff <= 1'b1;
                        lamp_ff <= 1'b1;
                        state_ff <= fault_pkg::ST_PON;
                    end
                end
                fault_pkg::ST_RGAP: begin
                    // Code repeats for as long as it stays selected
                    if (tcnt_ff == 4'(fault_pkg::REPEAT_GAP_T - 4'h1)) begin
                        tcnt_ff <= 4'h0;
                        pcnt_ff <= 4'h0;
                        dig_ff <= 1'b0;
                        lamp_ff <= 1'b1;
                        state_ff <= fault_pkg::ST_PON;
                    end
                end
                default: begin
                    state_ff <= fault_pkg::ST_IDLE;
                    lamp_ff <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    logic lamp_q_ff;
    logic [3:0] falls_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lamp_q_ff <= 1'b1;
            falls_ff <= 4'h0;
        end else begin
            lamp_q_ff <= lamp_ff;
            if (restart || !sh.code_valid || state_ff == fault_pkg::ST_RGAP) begin
                falls_ff <= 4'h0;
            end else if (lamp_q_ff && !lamp_ff) begin
                falls_ff <= 4'(falls_ff + 4'h1);
            end
        end
    end

    property p_first_digit_count;
        @(posedge mclk) disable iff (!rst_b)
        $rose(state_ff == fault_pkg::ST_DGAP) |-> (4'(falls_ff + 4'h1) == cur_ff[7:4]) && !lamp_ff;
    endproperty
    a_first_digit_count: assert property (p_first_digit_count) else $error("wrong pulse count before digit gap");
endmodule

// >>> bench/lamp_reader.sv
// Purpose: Far side model: an observer that reads the flashed code off the lamp
// Assumes: One tick is TICK cycles of mclk
// Notes: The first code after a change may be wrong, so callers take the second one
module lamp_reader #(
    parameter int unsigned TICK = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic lamp,
    output logic [7:0] seen_code_ff,
    output logic [7:0] n_codes_ff,
    output logic [15:0] lit_run_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] DGAP_MIN = 16'(3 * TICK);
    localparam logic [15:0] RGAP_MIN = 16'(6 * TICK);
    logic lamp_ff;
    logic [15:0] dark_run_ff;
    logic [3:0] pulses_ff;
    logic [3:0] tens_ff;

    // ==========================================================
    // Pulse counting
    // pulses and gaps
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lamp_ff <= 1'b1;
            dark_run_ff <= '0;
            lit_run_ff <= '0;
            pulses_ff <= '0;
            tens_ff <= '0;
            seen_code_ff <= '0;
            n_codes_ff <= '0;
        end else begin
            lamp_ff <= lamp;
            if (lamp) begin
                lit_run_ff <= lit_run_ff + 16'h1;
                dark_run_ff <= '0;
                if (!lamp_ff && dark_run_ff >= DGAP_MIN && dark_run_ff < RGAP_MIN) begin
                    tens_ff <= pulses_ff;
                    pulses_ff <= 4'h1;
                end else if (!lamp_ff) begin
                    pulses_ff <= pulses_ff + 4'h1;
                end
            end else begin
                lit_run_ff <= '0;
                dark_run_ff <= dark_run_ff + 16'h1;
                // Only the long gap closes a code, the digit gap is shorter
                if (dark_run_ff == RGAP_MIN) begin
                    seen_code_ff <= {tens_ff, pulses_ff};
                    n_codes_ff <= n_codes_ff + 8'h1;
                    pulses_ff <= '0;
                end
            end
        end
    end
endmodule

// >>> bench/fault_indicator_tb_top.sv
// Purpose: Self-checking bench for the fault lamp indicator
// Assumes: Short counts, TICK_CYCLES 4 and WIRE_HOLD_CYCLES 20
// Notes: Inputs change on the falling edge
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module fault_indicator_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk;
    logic rst_b;
    logic [9:0] fault_in;
    logic key_switch_input;
    logic [7:0] io_in;
    logic hist_clr;
    logic status_lamp;
    logic high_pedal_disable;
    logic [10:0] active_report;
    logic [10:0] history;
    logic [9:0] io_report;
    logic [7:0] seen_code;
    logic [7:0] n_codes;
    logic [15:0] lit_run;
    int n_fail = 0;
    int checks_done = 0;

    fault_indicator #(.TICK_CYCLES(4), .WIRE_HOLD_CYCLES(20)) dut (
        .mclk(mclk), .rst_b(rst_b), .fault_in(fault_in), .key_switch_input(key_switch_input),
        .io_in(io_in), .hist_clr(hist_clr), .status_lamp(status_lamp),
        .high_pedal_disable(high_pedal_disable), .active_report(active_report),
        .history(history), .io_report(io_report)
    );
    lamp_reader #(.TICK(4)) reader (
        .mclk(mclk), .rst_b(rst_b), .lamp(status_lamp), .seen_code_ff(seen_code),
        .n_codes_ff(n_codes), .lit_run_ff(lit_run)
    );

    // ==========================================================
    // Helpers
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic end_sim();
        $display("counts: checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Waits for two whole codes so the first, possibly cut, one is skipped
    task automatic see_code(input logic [7:0] exp);
        logic [7:0] n0;
        int i;
        n0 = n_codes;
        i = 0;
        while (n_codes !== n0 + 8'h2 && i < 400) begin
            cyc(1);
            i++;
        end
        if (i >= 400) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, n_codes, n0 + 8'h2);
            end_sim();
        end else begin
            `CHK(seen_code, exp)
        end
    endtask

    task automatic steady();
        cyc(16);
        `CHK(lit_run >= 16'h000c, 1'b1)
        `CHK(status_lamp, 1'b1)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        `CHK(status_lamp, 1'b1)
        `CHK({high_pedal_disable, active_report, history}, 23'h0)
        steady();
        $display("test reset done");
    endtask

    task automatic t_codes();
        logic [7:0] codes [10];
        codes = '{8'h11, 8'h12, 8'h14, 8'h15, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h31};
        for (int i = 0; i < 10; i++) begin
            fault_in = 10'h0;
            fault_in[i] = 1'b1;
            cyc(2);
            `CHK(active_report, {1'b0, fault_in})
            see_code(codes[i]);
            fault_in = 10'h0;
            steady();
        end
        $display("test codes done");
    endtask

    task automatic t_priority();
        fault_in = 10'h040;
        see_code(8'h23);
        fault_in[2] = 1'b1;
        see_code(8'h23);
        fault_in[6] = 1'b0;
        see_code(8'h14);
        $display("test priority done");
    endtask

    task automatic t_history();
        `CHK(history, 11'h3ff)
        hist_clr = 1'b1;
        cyc(1);
        hist_clr = 1'b0;
        cyc(1);
        `CHK(history, 11'h004)
        fault_in = 10'h0;
        cyc(2);
        hist_clr = 1'b1;
        cyc(1);
        hist_clr = 1'b0;
        cyc(2);
        `CHK(history, 11'h000)
        steady();
        $display("test history done");
    endtask

    task automatic t_io();
        io_in = 8'ha5;
        key_switch_input = 1'b1;
        cyc(2);
        `CHK(io_report, {1'b1, 1'b1, 8'ha5})
        io_in = 8'h5a;
        key_switch_input = 1'b0;
        cyc(2);
        `CHK(io_report, {1'b0, 1'b1, 8'h5a})
        $display("test io done");
    endtask

    task automatic t_hpd();
        int k;
        key_switch_input = 1'b1;
        fault_in = 10'h200;
        cyc(15);
        fault_in = 10'h000;
        cyc(1);
        fault_in = 10'h200;
        k = 0;
        while (high_pedal_disable !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        `CHK((k >= 20 && k <= 22), 1'b1)
        if (k >= 40) begin
            end_sim();
        end
        fault_in = 10'h000;
        cyc(4);
        `CHK(high_pedal_disable, 1'b1)
        `CHK(active_report, 11'h400)
        see_code(8'h32);
        key_switch_input = 1'b0;
        cyc(2);
        `CHK(high_pedal_disable, 1'b0)
        `CHK(history[10], 1'b1)
        steady();
        $display("test hpd done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        fault_in = 10'h0;
        key_switch_input = 1'b0;
        io_in = 8'h0;
        hist_clr = 1'b0;
        cyc(3);
        rst_b = 1'b1;
        t_reset();
        t_codes();
        t_priority();
        t_history();
        t_io();
        t_hpd();
        end_sim();
    end
endmodule
